// ==== smbts_device.sv ====
/*
  Device end: supervises the bus port as a slave. Detects start/stop,
  times clock-low (timeout) and clock-high (idle reset), enforces the
  slave stretch budget, detects bus-off, and offers a stretch request and
  a scaled current value from the user side.
  Assumes bus lines arrive asynchronously and are synchronised here.
*/
`timescale 1ns/10ps
`include "smbts_consts.svh"
module smbts_device #(
  parameter int unsigned TIMEOUT_CYC = `SMBTS_TIMEOUT_CYC,
  parameter int unsigned IDLE_CYC = `SMBTS_IDLE_CYC,
  parameter int unsigned SEXT_CYC = `SMBTS_SEXT_CYC,
  parameter int unsigned BUSOFF_CYC = `SMBTS_BUSOFF_CYC,
  parameter int unsigned REARM_CYC = `SMBTS_REARM_CYC,
  parameter int unsigned SCALE_W = `SMBTS_SCALE_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  smbts_if.device bus,
  input wire logic stretch_req,
  input wire logic pec_en,
  input wire logic [SCALE_W-1:0] spec_info_command,
  input wire logic [15:0] raw_current,
  output logic [15:0] reported_current,
  output logic in_msg,
  output logic timeout_flag,
  output logic idle_abort,
  output logic bus_off,
  output logic ready,
  output logic sext_over,
  output logic [7:0] pec_crc
);
  smbts_pkg::smbts_state_t state;
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic scl_p;
  logic sda_p;
  logic [31:0] low_cnt;
  logic [31:0] high_cnt;
  logic [31:0] off_cnt;
  logic [31:0] rearm_cnt;
  logic [31:0] sext;
  logic [2:0] bitc;
  logic [7:0] shift;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;

  function automatic logic [7:0] crc8_bit(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc8_bit = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
  endfunction : crc8_bit

  // ===========================================================
  // line synchronisers and events
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      scl_q <= 2'b11;
      sda_q <= 2'b11;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_q <= {scl_q[0], bus.bus_clock_line};
      sda_q <= {sda_q[0], bus.bus_data_line};
      scl_p <= scl_q[1];
      sda_p <= sda_q[1];
    end

  assign start_ev = scl_q[1] && scl_p && sda_p && !sda_q[1];
  assign stop_ev = scl_q[1] && scl_p && !sda_p && sda_q[1];
  assign rise_ev = scl_q[1] && !scl_p;

  // ===========================================================
  // transaction state
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      state <= smbts_pkg::smbts_idle;
    else if (clk_en)
    begin
      case (state)
        smbts_pkg::smbts_idle:
          if (off_cnt >= BUSOFF_CYC)
            state <= smbts_pkg::smbts_off;
          else if (start_ev)
            state <= smbts_pkg::smbts_active;
        smbts_pkg::smbts_active:
          if (low_cnt >= TIMEOUT_CYC || high_cnt >= IDLE_CYC)
            state <= smbts_pkg::smbts_abort;
          else if (stop_ev)
            state <= smbts_pkg::smbts_idle;
        smbts_pkg::smbts_abort:
          if (start_ev)
            state <= smbts_pkg::smbts_active;
          else if (off_cnt >= BUSOFF_CYC)
            state <= smbts_pkg::smbts_off;
        smbts_pkg::smbts_off:
          if (scl_q[1] || sda_q[1])
            state <= smbts_pkg::smbts_idle;
        default:
          state <= smbts_pkg::smbts_idle;
      endcase
    end

  // ===========================================================
  // clock-low, clock-high and bus-off timers
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      low_cnt <= 32'h0;
      high_cnt <= 32'h0;
      off_cnt <= 32'h0;
    end
    else if (clk_en)
    begin
      low_cnt <= scl_q[1] ? 32'h0 : low_cnt + 32'h1;
      high_cnt <= (!scl_q[1] || start_ev) ? 32'h0 : high_cnt + 32'h1;
      off_cnt <= (scl_q[1] || sda_q[1]) ? 32'h0 : off_cnt + 32'h1;
    end

  // ===========================================================
  // readiness after bus-off
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      rearm_cnt <= 32'h0;
      ready <= 1'b1;
    end
    else if (clk_en)
    begin
      if (state == smbts_pkg::smbts_off)
      begin
        rearm_cnt <= 32'h0;
        ready <= 1'b0;
      end
      else if (!ready)
      begin
        rearm_cnt <= rearm_cnt + 32'h1;
        if (rearm_cnt >= REARM_CYC - 1)
          ready <= 1'b1;
      end
    end

  // ===========================================================
  // status outputs: timeout_flag and idle_abort sticky until the next start; in_msg and bus_off follow the state
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      timeout_flag <= 1'b0;
      idle_abort <= 1'b0;
      in_msg <= 1'b0;
      bus_off <= 1'b0;
    end
    else if (clk_en)
    begin
      in_msg <= state == smbts_pkg::smbts_active;
      bus_off <= state == smbts_pkg::smbts_off;
      if (state == smbts_pkg::smbts_active && low_cnt >= TIMEOUT_CYC)
        timeout_flag <= 1'b1;
      else if (start_ev)
        timeout_flag <= 1'b0;
      if (state == smbts_pkg::smbts_active && high_cnt >= IDLE_CYC)
        idle_abort <= 1'b1;
      else if (start_ev)
        idle_abort <= 1'b0;
    end

  // ===========================================================
  // slave stretching within budget
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      sext <= 32'h0;
      sext_over <= 1'b0;
      bus.clk_oe_dev <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start_ev && state != smbts_pkg::smbts_active)
      begin
        sext <= 32'h0;
        sext_over <= 1'b0;
      end
      else if (bus.clk_oe_dev)
        sext <= sext + 32'h1;
      if (bus.clk_oe_dev && sext >= SEXT_CYC - 1)
        sext_over <= 1'b1;
      bus.clk_oe_dev <= stretch_req && !scl_q[1] && state == smbts_pkg::smbts_active
                        && !sext_over && !(bus.clk_oe_dev && sext >= SEXT_CYC - 1);
    end

  // ===========================================================
  // received bits fold into the packet error code
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      pec_crc <= 8'h00;
      bitc <= 3'h0;
      shift <= 8'h00;
      bus.dat_oe_dev <= 1'b0;
    end
    else if (clk_en)
    begin
      bus.dat_oe_dev <= 1'b0;
      if (start_ev)
      begin
        pec_crc <= 8'h00;
        bitc <= 3'h0;
      end
      else if (rise_ev && state == smbts_pkg::smbts_active)
      begin
        bitc <= bitc + 3'h1;
        shift <= {shift[6:0], sda_q[1]};
        if (pec_en)
          pec_crc <= crc8_bit(pec_crc, sda_q[1]);
      end
    end

  // ===========================================================
  // current reporting scale
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      reported_current <= 16'h0000;
    else if (clk_en)
      reported_current <= 16'($signed(raw_current) >>> spec_info_command);
endmodule : smbts_device

// ==== smbts_consts.svh ====
/*
  Timing constants for the bus port supervisor (device end and host end).
  Assumes a 100 MHz core clock; counts are derived from times in their own units.
*/
`ifndef SMBTS_CONSTS_SVH
`define SMBTS_CONSTS_SVH
`define SMBTS_CLK_MHZ 100
`define SMBTS_TIMEOUT_MS 30
`define SMBTS_TIMEOUT_CYC (`SMBTS_TIMEOUT_MS * 1000 * `SMBTS_CLK_MHZ)
`define SMBTS_IDLE_US 50
`define SMBTS_IDLE_CYC (`SMBTS_IDLE_US * `SMBTS_CLK_MHZ)
`define SMBTS_SEXT_MS 25
`define SMBTS_SEXT_CYC (`SMBTS_SEXT_MS * 1000 * `SMBTS_CLK_MHZ)
`define SMBTS_MEXT_MS 10
`define SMBTS_MEXT_CYC (`SMBTS_MEXT_MS * 1000 * `SMBTS_CLK_MHZ)
`define SMBTS_BUSOFF_S 2
`define SMBTS_BUSOFF_CYC (`SMBTS_BUSOFF_S * 1000 * 1000 * `SMBTS_CLK_MHZ)
`define SMBTS_REARM_MS 1
`define SMBTS_REARM_CYC (`SMBTS_REARM_MS * 1000 * `SMBTS_CLK_MHZ)
`define SMBTS_BUF_NS 4700
`define SMBTS_BUF_CYC ((`SMBTS_BUF_NS * `SMBTS_CLK_MHZ + 999) / 1000)
`define SMBTS_HDSTA_NS 4000
`define SMBTS_HDSTA_CYC ((`SMBTS_HDSTA_NS * `SMBTS_CLK_MHZ + 999) / 1000)
`define SMBTS_MCLK_KHZ_X10 512
`define SMBTS_MHALF_CYC ((`SMBTS_CLK_MHZ * 10000) / (`SMBTS_MCLK_KHZ_X10 * 2))
`define SMBTS_SLOW_KHZ 10
`define SMBTS_SLOW_HALF_CYC ((`SMBTS_CLK_MHZ * 1000) / (`SMBTS_SLOW_KHZ * 2))
`define SMBTS_FAST_KHZ 100
`define SMBTS_FAST_HALF_CYC ((`SMBTS_CLK_MHZ * 1000) / (`SMBTS_FAST_KHZ * 2))
`define SMBTS_SCALE_W 2
`endif

// ==== smbts_pkg.sv ====
/*
  Types shared by both ends of the bus port supervisor.
  Assumes smbts_consts.svh supplies the numbers.
*/
package smbts_pkg;
  typedef enum logic [1:0] {smbts_idle, smbts_active, smbts_abort, smbts_off} smbts_state_t;
  typedef enum logic [2:0] {smbts_m_idle, smbts_m_start, smbts_m_low, smbts_m_high,
                            smbts_m_stop, smbts_m_buf} smbts_mstate_t;
endpackage : smbts_pkg

// ==== smbts_if.sv ====
/*
  Two-wire bus between the host end and the device end.
  Assumes open-drain lines with pull-ups; a line is low while either end enables.
*/
`timescale 1ns/10ps
interface smbts_if;
  logic clk_oe_dev;
  logic dat_oe_dev;
  logic clk_oe_host;
  logic dat_oe_host;
  logic bus_clock_line;
  logic bus_data_line;
  assign bus_clock_line = !(clk_oe_dev || clk_oe_host);
  assign bus_data_line = !(dat_oe_dev || dat_oe_host);
  modport device (input bus_clock_line, input bus_data_line, output clk_oe_dev, output dat_oe_dev);
  modport host (input bus_clock_line, input bus_data_line, output clk_oe_host, output dat_oe_host);
endinterface : smbts_if

// ==== smbts_host.sv ====
/*
  Host end: a bus master that issues start, clocks n_bits plus one bits
  out and ends with stop, at a bus clock inside the slave's accepted range.
  Assumes the device end may stretch the clock low.
*/
`timescale 1ns/10ps
`include "smbts_consts.svh"
module smbts_host #(
  parameter int unsigned HALF_CYC = `SMBTS_MHALF_CYC,
  parameter int unsigned MEXT_CYC = `SMBTS_MEXT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  smbts_if.host bus,
  input wire logic go,
  input wire logic [7:0] n_bits,
  input wire logic [7:0] tx_byte,
  output logic busy,
  output logic mext_over
);
  localparam int unsigned BUF_CYC = `SMBTS_BUF_CYC;
  localparam int unsigned HD_CYC = `SMBTS_HDSTA_CYC;
  smbts_pkg::smbts_mstate_t state;
  logic [31:0] cnt;
  logic [31:0] ext;
  logic [7:0] bits;
  logic [7:0] sh;
  logic scl_m;
  logic scl_s;

  // ===========================================================
  // input synchroniser
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_m <= bus.bus_clock_line;
      scl_s <= scl_m;
    end

  // ===========================================================
  // master sequencer
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      state <= smbts_pkg::smbts_m_idle;
      cnt <= 32'h0;
      bits <= 8'h0;
      sh <= 8'h0;
      bus.clk_oe_host <= 1'b0;
      bus.dat_oe_host <= 1'b0;
      busy <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state)
        smbts_pkg::smbts_m_idle:
          if (go)
          begin
            state <= smbts_pkg::smbts_m_start;
            bus.dat_oe_host <= 1'b1;
            bits <= n_bits;
            sh <= tx_byte;
            cnt <= 32'h0;
            busy <= 1'b1;
          end
        smbts_pkg::smbts_m_start:
          if (cnt >= HD_CYC)
          begin
            bus.clk_oe_host <= 1'b1;
            cnt <= 32'h0;
            state <= smbts_pkg::smbts_m_low;
          end
          else
            cnt <= cnt + 32'h1;
        smbts_pkg::smbts_m_low:
          if (cnt == HALF_CYC / 2)
          begin
            bus.dat_oe_host <= !sh[7];
            cnt <= cnt + 32'h1;
          end
          else if (cnt >= HALF_CYC)
          begin
            bus.clk_oe_host <= 1'b0;
            cnt <= 32'h0;
            state <= smbts_pkg::smbts_m_high;
          end
          else
            cnt <= cnt + 32'h1;
        smbts_pkg::smbts_m_high:
          if (!scl_s)
            cnt <= 32'h0;
          else if (cnt >= HALF_CYC)
          begin
            cnt <= 32'h0;
            if (bits == 8'h0)
            begin
              bus.clk_oe_host <= 1'b1;
              state <= smbts_pkg::smbts_m_stop;
            end
            else
            begin
              bits <= bits - 8'h1;
              sh <= {sh[6:0], 1'b0};
              bus.clk_oe_host <= 1'b1;
              state <= smbts_pkg::smbts_m_low;
            end
          end
          else
            cnt <= cnt + 32'h1;
        // stop: data low under a low clock, clock up, then data up
        smbts_pkg::smbts_m_stop:
          if (cnt == HALF_CYC / 2)
          begin
            bus.dat_oe_host <= 1'b1;
            cnt <= cnt + 32'h1;
          end
          else if (cnt == HALF_CYC)
          begin
            bus.clk_oe_host <= 1'b0;
            cnt <= cnt + 32'h1;
          end
          else if (cnt > HALF_CYC && !scl_s)
            cnt <= HALF_CYC + 32'h1;
          else if (cnt >= HALF_CYC + HALF_CYC)
          begin
            bus.dat_oe_host <= 1'b0;
            cnt <= 32'h0;
            state <= smbts_pkg::smbts_m_buf;
          end
          else
            cnt <= cnt + 32'h1;
        smbts_pkg::smbts_m_buf:
          if (cnt >= BUF_CYC)
          begin
            busy <= 1'b0;
            state <= smbts_pkg::smbts_m_idle;
          end
          else
            cnt <= cnt + 32'h1;
        default:
          state <= smbts_pkg::smbts_m_idle;
      endcase
    end

  // ===========================================================
  // own extension budget: stretch of the high phase by a slave not counted
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      ext <= 32'h0;
      mext_over <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == smbts_pkg::smbts_m_start)
      begin
        ext <= 32'h0;
        mext_over <= 1'b0;
      end
      else if (state == smbts_pkg::smbts_m_low && cnt > HALF_CYC)
      begin
        ext <= ext + 32'h1;
        if (ext >= MEXT_CYC)
          mext_over <= 1'b1;
      end
    end
endmodule : smbts_host

// ==== smbts_chk_asserts.sv ====
/*
  Timing checker for the bus joining the host end and the device end.
  Assumes it watches the shared interface in the core clock domain.
*/
`timescale 1ns/10ps
module smbts_chk #(
  parameter int HALF_CYC = 40,
  parameter int SEXT_CYC = 100,
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_oe_dev,
  input wire logic dat_oe_dev,
  input wire logic clk_oe_host,
  input wire logic dat_oe_host,
  input wire logic bus_clock_line,
  input wire logic bus_data_line
);
  localparam int HD_MIN = 398;
  localparam int BUF_MIN = 469;
  logic pc;
  logic pd;
  logic ph;
  logic first;
  int hi_cnt;
  int lo_cnt;
  int free_cnt;
  int ext_cnt;
  int low_cnt;
  wire start_w = pc && bus_clock_line && pd && !bus_data_line;
  wire stop_w = pc && bus_clock_line && !pd && bus_data_line;
  // ==========
  // helper counters
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      {pc, pd, ph} <= 3'h6;
    else
      {pc, pd, ph} <= {bus_clock_line, bus_data_line, clk_oe_host};
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      first <= 1'b0;
    else if (start_w)
      first <= 1'b1;
    else if (clk_oe_host && !ph)
      first <= 1'b0;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      hi_cnt <= 0;
    else if (!bus_clock_line || start_w)
      hi_cnt <= 0;
    else if (hi_cnt < 100000)
      hi_cnt <= hi_cnt + 1;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      lo_cnt <= 0;
    else
      lo_cnt <= clk_oe_host ? lo_cnt + 1 : 0;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      low_cnt <= 0;
    else if (bus_clock_line)
      low_cnt <= 0;
    else if (low_cnt < TIMEOUT_CYC + 100)
      low_cnt <= low_cnt + 1;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      free_cnt <= BUF_MIN;
    else if (stop_w)
      free_cnt <= 0;
    else if (free_cnt < BUF_MIN)
      free_cnt <= free_cnt + 1;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      ext_cnt <= 0;
    else if (start_w)
      ext_cnt <= 0;
    else if (clk_oe_dev)
      ext_cnt <= ext_cnt + 1;
  // ==========
  // properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_start;
    $fell(bus_data_line) && bus_clock_line;
  endsequence
  sequence s_pull_low;
    $rose(clk_oe_host);
  endsequence
  chk_start_hold: assert property (s_pull_low |-> !first || hi_cnt >= HD_MIN)
    else $error("clock fell too soon after start");
  chk_bit_high: assert property (s_pull_low |-> first || (hi_cnt >= HALF_CYC - 1 &&
    hi_cnt <= HALF_CYC + 3))
    else $error("clock high phase off nominal");
  chk_bit_low: assert property ($fell(clk_oe_host) |-> lo_cnt >= HALF_CYC)
    else $error("clock low phase too short");
  chk_low_ext: assert property ($fell(clk_oe_host) |-> lo_cnt <= HALF_CYC + 1)
    else $error("master lengthened its own clock low");
  chk_bus_free: assert property (s_start |-> free_cnt >= BUF_MIN)
    else $error("start too soon after stop");
  chk_dev_data: assert property (!dat_oe_dev)
    else $error("device drove the data line");
  chk_stretch_sum: assert property (ext_cnt <= SEXT_CYC + 3)
    else $error("slave stretch over budget");
  chk_stretch_low: assert property ($rose(clk_oe_dev) |-> !$past(bus_clock_line))
    else $error("stretch began with clock high");
  chk_timeout_free: assert property (low_cnt > TIMEOUT_CYC + 8 |-> !clk_oe_dev)
    else $error("clock held past timeout");
  cover property (s_start);
endmodule : smbts_chk

// ==== smbus_port_timing_supervisor_tb.sv ====
/*
  Bench: host end and device end on one bus, plus a second device end
  whose bus the bench drives to break the timing on purpose.
  Assumes the design files and smbts_consts.svh compile first.
*/
`timescale 1ns/10ps
module smbus_port_timing_supervisor_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic go = 1'b0;
  logic [7:0] n_bits = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  logic stretch_req = 1'b0;
  logic pec_en = 1'b1;
  logic [1:0] spec_info_command = 2'h0;
  logic [15:0] raw_current = 16'h0000;
  logic busy, mext_over, in_msg, timeout_flag, idle_abort, bus_off, ready, sext_over;
  logic in2, tmo2, idl2, off2, rdy2;
  logic [15:0] reported_current;
  logic [7:0] pec_crc;
  logic pc, pd;
  logic [7:0] crc, cap;
  int nb;
  int n_mismatch = 0;
  int n_tests = 0;
  // shortened timing; idle limit must exceed the start hold and a half bit
  localparam int HALF = 40;
  localparam int TMO = 200;
  localparam int IDLE = 450;
  localparam int SEXT = 100;
  localparam int BOFF = 300;
  localparam int REARM = 20;
  logic [15:0] scaled [4] = '{16'h9a40, 16'hcd20, 16'he690, 16'hf348};
  smbts_if bus();
  smbts_if bus2();
  always #5 core_clk = ~core_clk;
  smbts_host #(.HALF_CYC(HALF)) smbts_host_inst (.core_clk(core_clk),
    .rst_b(rst_b), .clk_en(clk_en), .bus(bus), .go(go), .n_bits(n_bits),
    .tx_byte(tx_byte), .busy(busy), .mext_over(mext_over));
  smbts_device #(.TIMEOUT_CYC(TMO), .IDLE_CYC(IDLE), .SEXT_CYC(SEXT), .BUSOFF_CYC(BOFF),
    .REARM_CYC(REARM)) smbts_device_inst (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .bus(bus), .stretch_req(stretch_req), .pec_en(pec_en),
    .spec_info_command(spec_info_command), .raw_current(raw_current),
    .reported_current(reported_current), .in_msg(in_msg), .timeout_flag(timeout_flag),
    .idle_abort(idle_abort), .bus_off(bus_off), .ready(ready), .sext_over(sext_over),
    .pec_crc(pec_crc));
  smbts_device #(.TIMEOUT_CYC(TMO), .IDLE_CYC(IDLE), .SEXT_CYC(SEXT), .BUSOFF_CYC(BOFF),
    .REARM_CYC(REARM)) smbts_device_inst2 (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .bus(bus2), .stretch_req(stretch_req), .pec_en(pec_en),
    .spec_info_command(spec_info_command), .raw_current(raw_current),
    .reported_current(), .in_msg(in2), .timeout_flag(tmo2), .idle_abort(idl2),
    .bus_off(off2), .ready(rdy2), .sext_over(), .pec_crc());
  smbts_chk #(.HALF_CYC(HALF), .SEXT_CYC(SEXT), .TIMEOUT_CYC(TMO)) smbts_chk_inst (
    .core_clk(core_clk), .rst_b(rst_b), .clk_oe_dev(bus.clk_oe_dev),
    .dat_oe_dev(bus.dat_oe_dev), .clk_oe_host(bus.clk_oe_host),
    .dat_oe_host(bus.dat_oe_host), .bus_clock_line(bus.bus_clock_line),
    .bus_data_line(bus.bus_data_line));
  // ==========
  // wire monitor: bits on clock rise, crc-8 poly 07
  always @(posedge core_clk)
  begin
    pc <= bus.bus_clock_line;
    pd <= bus.bus_data_line;
    if (pc && bus.bus_clock_line && pd && !bus.bus_data_line)
    begin
      crc <= 8'h00;
      nb <= 0;
    end
    else if (!pc && bus.bus_clock_line)
    begin
      crc <= {crc[6:0], 1'b0} ^ ((crc[7] ^ bus.bus_data_line) ? 8'h07 : 8'h00);
      if (nb < 8)
        cap <= {cap[6:0], bus.bus_data_line};
      nb <= nb + 1;
    end
  end
  // ==========
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic xfer(input logic [7:0] n, input logic [7:0] b);
    int i;
    cyc(1);
    n_bits = n;
    tx_byte = b;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (i = 0; i < 8000 && busy !== 1'b0; i++)
      cyc(1);
    chk(busy, 1'b0);
  endtask : xfer
  task automatic drv(input logic c, input logic d, input int n);
    bus2.clk_oe_host = c;
    bus2.dat_oe_host = d;
    cyc(n);
  endtask : drv
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    #400000;
    n_mismatch++;
    results();
  end
  initial
  begin
    int i;
    bus2.clk_oe_host = 1'b0;
    bus2.dat_oe_host = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    cyc(3);
    chk(ready, 1'b1);
    chk({in_msg, timeout_flag, idle_abort, bus_off, sext_over}, 5'h00);
    $display("test reset done");
    xfer(8'h07, 8'ha5);
    chk(cap, 8'ha5);
    chk(pec_crc, crc);
    chk({in_msg, timeout_flag, idle_abort}, 3'h0);
    $display("test transfer done");
    raw_current = 16'h9a40;
    for (i = 0; i < 4; i++)
    begin
      spec_info_command = i[1:0];
      cyc(2);
      chk(reported_current, scaled[i]);
    end
    // clock enable low: output must hold its last value
    clk_en = 1'b0;
    raw_current = 16'h1234;
    cyc(3);
    chk(reported_current, scaled[3]);
    clk_en = 1'b1;
    $display("test scaling done");
    stretch_req = 1'b1;
    xfer(8'h07, 8'h3c);
    chk(sext_over, 1'b1);
    chk(mext_over, 1'b0);
    chk(cap, 8'h3c);
    chk(pec_crc, crc);
    stretch_req = 1'b0;
    pec_en = 1'b0;
    xfer(8'h00, 8'h80);
    chk(sext_over, 1'b0);
    chk(pec_crc, 8'h00);
    $display("test stretch done");
    drv(1'b0, 1'b1, 10);
    drv(1'b1, 1'b1, 30);
    chk(in2, 1'b1);
    drv(1'b0, 1'b1, IDLE + 50);
    chk({idl2, in2}, 2'h2);
    drv(1'b1, 1'b1, 30);
    drv(1'b0, 1'b1, 20);
    drv(1'b1, 1'b1, 30);
    chk(in2, 1'b0);
    drv(1'b0, 1'b1, 10);
    drv(1'b0, 1'b0, 20);
    drv(1'b0, 1'b1, 10);
    chk({idl2, in2}, 2'h1);
    drv(1'b1, 1'b1, 250);
    chk({tmo2, in2, bus2.clk_oe_dev}, 3'h4);
    drv(1'b1, 1'b1, 100);
    chk({off2, rdy2}, 2'h2);
    drv(1'b0, 1'b1, 5);
    chk(off2, 1'b0);
    for (i = 0; i < 40 && rdy2 !== 1'b1; i++)
      cyc(1);
    chk(rdy2, 1'b1);
    drv(1'b0, 1'b0, 5);
    $display("test faults done");
    results();
  end
endmodule : smbus_port_timing_supervisor_tb
